// file: hdl/ptc_pkg.sv
`default_nettype none
package ptc_pkg;
  // ----------------------------------------------------------------
  // register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] TSI_CFG_IDX = 10'h041; // timestamp_indication_config
  localparam logic [9:0] TXCPS_IDX = 10'h042; // tx_clock_phase_shift
  localparam logic [9:0] PBO_IDX = 10'h0AE; // power_back_off_control
  localparam logic [9:0] VRC_IDX = 10'h0D0; // regulator_control
  // ----------------------------------------------------------------
  // timestamp_indication_config fields
  // ----------------------------------------------------------------
  localparam int TSI_TX_LSB = 13;
  localparam int TSI_RX_LSB = 10;
  localparam int TSI_ERR_LSB = 8;
  localparam logic [2:0] TSI_TX_RST = 3'h5;
  localparam logic [2:0] TSI_RX_RST = 3'h5;
  localparam logic [1:0] TSI_ERR_RST = 2'h0;
  localparam logic [7:0] TSI_LOW_RST = 8'h44;
  // tx error source codes
  localparam logic [1:0] ERR_NONE = 2'h0;
  localparam logic [1:0] ERR_ACT = 2'h1;
  localparam logic [1:0] ERR_PWD = 2'h2;
  localparam logic [1:0] ERR_COL = 2'h3;
  // ----------------------------------------------------------------
  // tx_clock_phase_shift fields
  // ----------------------------------------------------------------
  localparam int TXC_EN_BIT = 4;
  localparam logic [3:0] TXC_VAL_RST = 4'h0;
  localparam logic [3:0] TXC_VAL_MAX = 4'hA;
  localparam int TXC_STEP_NS = 4;
  // ----------------------------------------------------------------
  // power_back_off_control and regulator_control fields
  // ----------------------------------------------------------------
  localparam int PBO_LSB = 6;
  localparam logic [2:0] PBO_RST = 3'h0;
  localparam logic [2:0] PBO_MAX = 3'h3;
  localparam logic [15:0] PBO_FIXED = 16'h8020;
  localparam int VRC_PD_BIT = 15;
  localparam logic [10:0] VRC_RSV_RST = 11'h000;
  localparam logic [3:0] VRC_CTL_RST = 4'h0;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int SFD_STEP_NS = 8;
  // least delay for the largest setting, rounded up to whole cycles
  localparam int SFD_MAX_CYC = (7 * SFD_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// file: hdl/ptc_pulse_delay.sv
`default_nettype none
// delays a one-bit indication by a selectable number of cycles
module ptc_pulse_delay #(
  parameter int MAX_CYC = 12
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [3:0] delay_cyc,
  input wire logic pulse_in,
  output logic pulse_out
);
  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (MAX_CYC < 1 || MAX_CYC > 15) begin : g_bad_depth
    $error("ptc_pulse_delay: MAX_CYC out of range");
  end

  logic [MAX_CYC:0] tap_ff; // tap 0 is the input one cycle late
  logic [MAX_CYC:0] nxt_tap;
  logic out_ff;
  logic nxt_out;

  // ----------------------------------------------------------------
  // shift chain and tap selection
  // ----------------------------------------------------------------
  always_comb begin
    nxt_tap = {tap_ff[MAX_CYC-1:0], pulse_in};
    nxt_out = tap_ff[0];
    // settings beyond the chain clamp to its end
    if (int'(delay_cyc) >= MAX_CYC) begin
      nxt_out = tap_ff[MAX_CYC];
    end else begin
      nxt_out = tap_ff[delay_cyc];
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tap_ff <= '0;
      out_ff <= 1'b0;
    end else begin
      tap_ff <= nxt_tap;
      out_ff <= nxt_out;
    end
  end

  assign pulse_out = out_ff;
endmodule
`default_nettype wire

// file: hdl/ptc_regs.sv
// Design decision made here: the APB interface to the registers.
`default_nettype none
// Contract
// R01 - tx timestamp delay, 3 bits, 8ns, reset 101
// R02 - rx timestamp delay, 3 bits, 8ns, reset 101
// R03 - two-bit tx error source pin selector
// R04 - tx clock phase 0..10 in 4ns units
// R05 - phase above ten stored modulo ten
// R06 - shift equals four ns times difference
// R07 - self-clearing enable triggers shift; zero no change
// R08 - back-off level: normal, levels one to three
// R09 - self-clearing bit powers regulator down
// R10 - host writes reserved regulator bits as zero
// R11 - host reads before writing regulator control
// R12 - phase register upper bits read zero
// R13 - delayed indications go to selected pins
module ptc_regs #(
  parameter int SFD_MAX_CYC = ptc_pkg::SFD_MAX_CYC
) (
  input wire logic ref_clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // timestamp indications from the datapath
  input wire logic tx_sfd_in,
  input wire logic rx_sfd_in,
  input wire logic [2:0] tx_pin_sel,
  input wire logic [2:0] rx_pin_sel,
  output logic [5:0] sfd_pin_out,
  // candidate tx error pins
  input wire logic activity_led_pin,
  input wire logic power_down_pin,
  input wire logic collision_pin,
  output logic tx_err,
  // tx clock phase control
  output logic [3:0] tx_clk_phase,
  output logic signed [6:0] tx_clk_shift_ns,
  output logic tx_clk_shift_stb,
  // power back-off and regulator
  output logic [2:0] power_back_off_level,
  output logic regulator_power_down,
  output logic regulator_output_pin_en,
  output logic [3:0] regulator_ctrl
);
  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (SFD_MAX_CYC < ptc_pkg::SFD_MAX_CYC || SFD_MAX_CYC > 15) begin : g_bad_cyc
    $error("ptc_regs: SFD_MAX_CYC cannot hold the longest delay");
  end
  // ----------------------------------------------------------------
  // apb access
  // ----------------------------------------------------------------
  logic pready_ff, nxt_pready; // one wait state, then answer
  logic pslverr_ff, nxt_pslverr;
  logic [31:0] prdata_ff, nxt_prdata;
  logic wr_go; // write takes effect this edge
  logic hit_tsi, hit_txc, hit_pbo, hit_vrc, hit_any;
  logic [9:0] idx;
  // address decode
  always_comb begin
    idx = paddr[11:2];
    hit_tsi = 1'b0;
    hit_txc = 1'b0;
    hit_pbo = 1'b0;
    hit_vrc = 1'b0;
    // unaligned addresses match nothing
    if (paddr[1:0] != 2'h0) begin
      hit_tsi = 1'b0;
    end else if (idx == ptc_pkg::TSI_CFG_IDX) begin
      hit_tsi = 1'b1;
    end else if (idx == ptc_pkg::TXCPS_IDX) begin
      hit_txc = 1'b1;
    end else if (idx == ptc_pkg::PBO_IDX) begin
      hit_pbo = 1'b1;
    end else if (idx == ptc_pkg::VRC_IDX) begin
      hit_vrc = 1'b1;
    end
    hit_any = hit_tsi | hit_txc | hit_pbo | hit_vrc;
  end
  assign wr_go = psel & penable & pready_ff & pwrite & hit_any;
  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [2:0] tx_dly_ff, nxt_tx_dly;
  logic [2:0] rx_dly_ff, nxt_rx_dly;
  logic [1:0] err_sel_ff, nxt_err_sel;
  logic [7:0] tsi_low_ff, nxt_tsi_low; // reserved but writable
  logic [3:0] phase_val_ff, nxt_phase_val; // stored phase
  logic phase_en_ff, nxt_phase_en; // self-clearing trigger
  logic [2:0] pbo_ff, nxt_pbo;
  logic vr_pd_bit_ff, nxt_vr_pd_bit; // self-clearing bit
  logic [10:0] vr_rsv_ff, nxt_vr_rsv;
  logic [3:0] vr_ctl_ff, nxt_vr_ctl;
  logic [3:0] wr_phase; // written value after wrap
  logic [15:0] rd_word;
  // next values of the software-visible fields
  always_comb begin
    nxt_tx_dly = tx_dly_ff;
    nxt_rx_dly = rx_dly_ff;
    nxt_err_sel = err_sel_ff;
    nxt_tsi_low = tsi_low_ff;
    nxt_phase_val = phase_val_ff;
    nxt_phase_en = 1'b0;
    nxt_pbo = pbo_ff;
    nxt_vr_pd_bit = 1'b0;
    nxt_vr_rsv = vr_rsv_ff;
    nxt_vr_ctl = vr_ctl_ff;
    // values above ten wrap modulo ten
    if (pwdata[3:0] > ptc_pkg::TXC_VAL_MAX) begin
      wr_phase = 4'(pwdata[3:0] - ptc_pkg::TXC_VAL_MAX); // R05
    end else begin
      wr_phase = pwdata[3:0];
    end
    if (wr_go && hit_tsi) begin
      nxt_tx_dly = pwdata[ptc_pkg::TSI_TX_LSB +: 3]; // R01
      nxt_rx_dly = pwdata[ptc_pkg::TSI_RX_LSB +: 3]; // R02
      nxt_err_sel = pwdata[ptc_pkg::TSI_ERR_LSB +: 2]; // R03
      nxt_tsi_low = pwdata[7:0];
    end else if (wr_go && hit_txc) begin
      // upper bits are simply dropped
      nxt_phase_val = wr_phase; // R04 R12
      nxt_phase_en = pwdata[ptc_pkg::TXC_EN_BIT]; // R07
    end else if (wr_go && hit_pbo) begin
      nxt_pbo = pwdata[ptc_pkg::PBO_LSB +: 3]; // R08
    end else if (wr_go && hit_vrc) begin
      nxt_vr_pd_bit = pwdata[ptc_pkg::VRC_PD_BIT]; // R09
      nxt_vr_rsv = pwdata[14:4]; // R10
      nxt_vr_ctl = pwdata[3:0]; // R11
    end
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tx_dly_ff <= ptc_pkg::TSI_TX_RST;
      rx_dly_ff <= ptc_pkg::TSI_RX_RST;
      err_sel_ff <= ptc_pkg::TSI_ERR_RST;
      tsi_low_ff <= ptc_pkg::TSI_LOW_RST;
      phase_val_ff <= ptc_pkg::TXC_VAL_RST;
      phase_en_ff <= 1'b0;
      pbo_ff <= ptc_pkg::PBO_RST;
      vr_pd_bit_ff <= 1'b0;
      vr_rsv_ff <= ptc_pkg::VRC_RSV_RST;
      vr_ctl_ff <= ptc_pkg::VRC_CTL_RST;
    end else begin
      tx_dly_ff <= nxt_tx_dly;
      rx_dly_ff <= nxt_rx_dly;
      err_sel_ff <= nxt_err_sel;
      tsi_low_ff <= nxt_tsi_low;
      phase_val_ff <= nxt_phase_val;
      phase_en_ff <= nxt_phase_en;
      pbo_ff <= nxt_pbo;
      vr_pd_bit_ff <= nxt_vr_pd_bit;
      vr_rsv_ff <= nxt_vr_rsv;
      vr_ctl_ff <= nxt_vr_ctl;
    end
  end
  // read mux and bus answer
  always_comb begin
    rd_word = 16'h0000;
    if (hit_tsi) begin
      rd_word = {tx_dly_ff, rx_dly_ff, err_sel_ff, tsi_low_ff};
    end else if (hit_txc) begin
      // upper bits always zero
      rd_word = {11'h000, phase_en_ff, phase_val_ff}; // R12
    end else if (hit_pbo) begin
      rd_word = ptc_pkg::PBO_FIXED | {7'h00, pbo_ff, 6'h00};
    end else if (hit_vrc) begin
      rd_word = {vr_pd_bit_ff, vr_rsv_ff, vr_ctl_ff};
    end
    nxt_pready = psel & penable & ~pready_ff;
    nxt_pslverr = psel & penable & ~pready_ff & ~hit_any;
    nxt_prdata = 32'h0000_0000;
    // data only on a mapped read
    if (psel && penable && !pready_ff && !pwrite && hit_any) begin
      nxt_prdata = {16'h0000, rd_word};
    end
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff <= nxt_prdata;
    end
  end

  // ----------------------------------------------------------------
  // tx clock phase tracking
  // ----------------------------------------------------------------
  logic [3:0] phase_app_ff, nxt_phase_app; // phase now in force
  logic signed [6:0] shift_ns_ff, nxt_shift_ns;
  logic shift_stb_ff, nxt_shift_stb;
  // the trigger acts the cycle after the write lands
  always_comb begin
    nxt_phase_app = phase_app_ff;
    nxt_shift_ns = shift_ns_ff;
    nxt_shift_stb = 1'b0;
    if (phase_en_ff && phase_val_ff != phase_app_ff) begin
      nxt_phase_app = phase_val_ff; // R07
      nxt_shift_ns = 7'(ptc_pkg::TXC_STEP_NS * (int'(phase_val_ff) - int'(phase_app_ff))); // R06
      nxt_shift_stb = 1'b1;
    end
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      phase_app_ff <= ptc_pkg::TXC_VAL_RST;
      shift_ns_ff <= 7'sh00;
      shift_stb_ff <= 1'b0;
    end else begin
      phase_app_ff <= nxt_phase_app;
      shift_ns_ff <= nxt_shift_ns;
      shift_stb_ff <= nxt_shift_stb;
    end
  end
  // ----------------------------------------------------------------
  // tx error pin selection
  // ----------------------------------------------------------------
  logic [2:0] pin_s1_ff, pin_s2_ff, pin_s3_ff; // synchroniser stages
  logic [2:0] pin_ok_ff, nxt_pin_ok; // accepted levels
  logic err_ff, nxt_err;
  // accept a change once stages two and three agree
  always_comb begin
    nxt_pin_ok = pin_ok_ff;
    for (int i = 0; i < 3; i++) begin
      if (pin_s2_ff[i] == pin_s3_ff[i]) begin
        nxt_pin_ok[i] = pin_s3_ff[i];
      end
    end
    case (err_sel_ff)
      ptc_pkg::ERR_ACT: nxt_err = pin_ok_ff[0]; // R03
      ptc_pkg::ERR_PWD: nxt_err = pin_ok_ff[1]; // R03
      ptc_pkg::ERR_COL: nxt_err = pin_ok_ff[2]; // R03
      default: nxt_err = 1'b0;
    endcase
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pin_s1_ff <= 3'h0;
      pin_s2_ff <= 3'h0;
      pin_s3_ff <= 3'h0;
      pin_ok_ff <= 3'h0;
      err_ff <= 1'b0;
    end else begin
      pin_s1_ff <= {collision_pin, power_down_pin, activity_led_pin};
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      pin_ok_ff <= nxt_pin_ok;
      err_ff <= nxt_err;
    end
  end

  // ----------------------------------------------------------------
  // delayed timestamp indications
  // ----------------------------------------------------------------
  logic [3:0] tx_cyc, rx_cyc;
  logic tx_dly_pulse, rx_dly_pulse;
  // steps of 8 ns rounded up to whole cycles
  always_comb begin
    tx_cyc = 4'((int'(tx_dly_ff) * ptc_pkg::SFD_STEP_NS + ptc_pkg::CLK_PERIOD_NS - 1)
                / ptc_pkg::CLK_PERIOD_NS); // R01
    rx_cyc = 4'((int'(rx_dly_ff) * ptc_pkg::SFD_STEP_NS + ptc_pkg::CLK_PERIOD_NS - 1)
                / ptc_pkg::CLK_PERIOD_NS); // R02
  end
  // one delay chain per direction, both of the same depth
  ptc_pulse_delay #(.MAX_CYC(SFD_MAX_CYC)) u_tx_delay (
    .ref_clk(ref_clk), .reset(reset), .delay_cyc(tx_cyc), .pulse_in(tx_sfd_in), .pulse_out(tx_dly_pulse)
  );
  ptc_pulse_delay #(.MAX_CYC(SFD_MAX_CYC)) u_rx_delay (
    .ref_clk(ref_clk), .reset(reset), .delay_cyc(rx_cyc), .pulse_in(rx_sfd_in), .pulse_out(rx_dly_pulse)
  );
  logic [5:0] sfd_pin_ff, nxt_sfd_pin;
  // pin code n drives pin n-1; code zero drives none
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      nxt_sfd_pin[i] = (tx_dly_pulse && tx_pin_sel == 3'(i + 1))
                     | (rx_dly_pulse && rx_pin_sel == 3'(i + 1)); // R13
    end
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sfd_pin_ff <= 6'h00;
    end else begin
      sfd_pin_ff <= nxt_sfd_pin;
    end
  end

  // ----------------------------------------------------------------
  // back-off level and regulator control
  // ----------------------------------------------------------------
  logic [2:0] pbo_out_ff, nxt_pbo_out;
  logic vr_down_ff, nxt_vr_down; // stays down until reset
  logic pin_en_ff, nxt_pin_en; // regulator output driven while powered
  logic [3:0] vr_ctl_out_ff;
  // reserved back-off codes fall back to normal drive
  always_comb begin
    nxt_pbo_out = (pbo_ff > ptc_pkg::PBO_MAX) ? ptc_pkg::PBO_RST : pbo_ff; // R08
    nxt_vr_down = vr_down_ff | vr_pd_bit_ff; // R09
    nxt_pin_en = ~nxt_vr_down; // R09
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pbo_out_ff <= ptc_pkg::PBO_RST;
      vr_down_ff <= 1'b0;
      pin_en_ff <= 1'b1;
      vr_ctl_out_ff <= ptc_pkg::VRC_CTL_RST;
    end else begin
      pbo_out_ff <= nxt_pbo_out;
      vr_down_ff <= nxt_vr_down;
      pin_en_ff <= nxt_pin_en;
      vr_ctl_out_ff <= vr_ctl_ff;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign sfd_pin_out = sfd_pin_ff;
  assign tx_err = err_ff;
  assign tx_clk_phase = phase_app_ff;
  assign tx_clk_shift_ns = shift_ns_ff;
  assign tx_clk_shift_stb = shift_stb_ff;
  assign power_back_off_level = pbo_out_ff;
  assign regulator_power_down = vr_down_ff;
  assign regulator_output_pin_en = pin_en_ff;
  assign regulator_ctrl = vr_ctl_out_ff;
endmodule
`default_nettype wire

// file: verification/ptc_regs_asserts.sv
`default_nettype none
// watches the bus answer, the clock phase control and the regulator outputs
module ptc_regs_asserts #(
  parameter int SFD_MAX_CYC = 12
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] tx_clk_phase,
  input wire logic signed [6:0] tx_clk_shift_ns,
  input wire logic tx_clk_shift_stb,
  input wire logic [2:0] power_back_off_level,
  input wire logic regulator_power_down,
  input wire logic regulator_output_pin_en
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  logic phase_wr; // completed write to the phase register
  logic vreg_wr; // completed write to the regulator register
  logic [3:0] ph_mod; // written phase folded into 0..10
  assign phase_wr = pready && psel && penable && pwrite && paddr == 12'h108;
  assign vreg_wr = pready && psel && penable && pwrite && paddr == 12'h340;
  assign ph_mod = (pwdata[3:0] > 4'hA) ? pwdata[3:0] - 4'hA : pwdata[3:0];
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_ONE_WAIT: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("answer not after exactly one wait");
  AST_READY_PULSE: assert property (pready |=> !pready) else $error("ready longer than one cycle");
  AST_ERR_DATA: assert property (pslverr |-> pready && prdata == 32'h0) else $error("error answer carries data");
  AST_PHASE_RANGE: assert property (tx_clk_phase <= 4'hA) else $error("phase above ten");
  AST_PHASE_MOD: assert property (phase_wr && pwdata[4] |-> ##2 tx_clk_phase == $past(ph_mod, 2))
    else $error("applied phase not folded value");
  AST_STB_CAUSE: assert property (tx_clk_shift_stb |-> $past(phase_wr && pwdata[4], 2))
    else $error("shift without enabled write");
  AST_STB_NEEDED: assert property (phase_wr && pwdata[4] && ph_mod != tx_clk_phase |-> ##2 tx_clk_shift_stb)
    else $error("enabled write did not shift");
  AST_SHIFT_AMOUNT: assert property (tx_clk_shift_stb |->
    tx_clk_shift_ns == ($signed({3'b000, tx_clk_phase}) - $signed({3'b000, $past(tx_clk_phase)})) * 7'sd4)
    else $error("shift amount wrong");
  AST_VREG_DOWN: assert property (vreg_wr && pwdata[15] |-> ##2 regulator_power_down)
    else $error("regulator not powered down");
  AST_VREG_PIN: assert property (regulator_output_pin_en != regulator_power_down)
    else $error("regulator pin enable wrong");
  AST_BACKOFF_RANGE: assert property (power_back_off_level <= 3'h3) else $error("reserved level driven");
  AST_PHASE_RSV_ZERO: assert property (pready && !pwrite && paddr == 12'h108 |-> prdata[31:5] == 27'h0)
    else $error("phase upper bits not zero");
  // ----------------------------------------------------------------
  // covers
  // ----------------------------------------------------------------
  COV_SHIFT: cover property (tx_clk_shift_stb && tx_clk_shift_ns < 0);
  COV_VREG: cover property ($rose(regulator_power_down));
  COV_ERR: cover property (pslverr);
endmodule
bind ptc_regs ptc_regs_asserts #(.SFD_MAX_CYC(SFD_MAX_CYC)) i_ptc_regs_asserts (
  .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tx_clk_phase(tx_clk_phase), .tx_clk_shift_ns(tx_clk_shift_ns), .tx_clk_shift_stb(tx_clk_shift_stb),
  .power_back_off_level(power_back_off_level), .regulator_power_down(regulator_power_down),
  .regulator_output_pin_en(regulator_output_pin_en)
);
`default_nettype wire

// file: verification/ptc_mac_model.sv
`default_nettype none
// datapath stand-in: start-of-frame indications and candidate error pins
module ptc_mac_model (
  input wire logic ref_clk,
  output var logic tx_sfd_in,
  output var logic rx_sfd_in,
  output var logic activity_led_pin,
  output var logic power_down_pin,
  output var logic collision_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // idle levels
  // ----------------------------------------------------------------
  initial begin
    tx_sfd_in = 1'b0;
    rx_sfd_in = 1'b0;
    activity_led_pin = 1'b0;
    power_down_pin = 1'b0;
    collision_pin = 1'b0;
  end
  // one-cycle indication, changed just after an edge
  task automatic pulse(input logic rx);
    @(posedge ref_clk);
    if (rx) rx_sfd_in <= 1'b1;
    else tx_sfd_in <= 1'b1;
    @(posedge ref_clk);
    rx_sfd_in <= 1'b0;
    tx_sfd_in <= 1'b0;
  endtask
  // pin levels are slow; the design resynchronises them
  task automatic set_pins(input logic a, input logic p, input logic c);
    @(posedge ref_clk);
    activity_led_pin <= a;
    power_down_pin <= p;
    collision_pin <= c;
  endtask
endmodule
`default_nettype wire

// file: verification/ptc_regs_bench.sv
`default_nettype none
module ptc_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, tx_sfd_in, rx_sfd_in, tx_err, tx_clk_shift_stb;
  logic activity_led_pin, power_down_pin, collision_pin, regulator_power_down, regulator_output_pin_en;
  logic [2:0] tx_pin_sel = 3'h0, rx_pin_sel = 3'h0, power_back_off_level;
  logic [5:0] sfd_pin_out;
  logic [3:0] tx_clk_phase, regulator_ctrl;
  logic signed [6:0] tx_clk_shift_ns;
  // phase writes, expected applied phase and shift amount
  logic [4:0] ph_wr [4] = '{5'h12, 5'h19, 5'h1D, 5'h07};
  logic [3:0] ph_exp [4] = '{4'h2, 4'h9, 4'h3, 4'h3};
  logic [6:0] sh_exp [4] = '{7'h08, 7'h1C, 7'h68, 7'h68};
  int num_errors = 0, comparisons = 0, n;
  always #2.5 ref_clk = ~ref_clk;
  ptc_regs #(.SFD_MAX_CYC(12)) i_ptc_regs (
    .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_sfd_in(tx_sfd_in), .rx_sfd_in(rx_sfd_in), .tx_pin_sel(tx_pin_sel), .rx_pin_sel(rx_pin_sel),
    .sfd_pin_out(sfd_pin_out), .activity_led_pin(activity_led_pin), .power_down_pin(power_down_pin),
    .collision_pin(collision_pin), .tx_err(tx_err), .tx_clk_phase(tx_clk_phase),
    .tx_clk_shift_ns(tx_clk_shift_ns), .tx_clk_shift_stb(tx_clk_shift_stb),
    .power_back_off_level(power_back_off_level), .regulator_power_down(regulator_power_down),
    .regulator_output_pin_en(regulator_output_pin_en), .regulator_ctrl(regulator_ctrl)
  );
  ptc_mac_model i_ptc_mac_model (
    .ref_clk(ref_clk), .tx_sfd_in(tx_sfd_in), .rx_sfd_in(rx_sfd_in), .activity_led_pin(activity_led_pin),
    .power_down_pin(power_down_pin), .collision_pin(collision_pin)
  );
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // one bus transfer; request held until ready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      end_of_test();
    end
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp, "read data");
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    rdchk(12'h104, 32'h0000B444);
    rdchk(12'h108, 32'h00000000);
    rdchk(12'h2B8, 32'h00008020);
    $display("reset values done");
    // every error source code, activity and collision pins high, power-down pin low
    i_ptc_mac_model.set_pins(1'b1, 1'b0, 1'b1);
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, 12'h104, 32'h0000B444 | (s << 8));
      repeat (8) @(posedge ref_clk);
      check(32'(tx_err), 32'(s % 2), "error source");
    end
    $display("error source done");
    // tx delay 5 steps, rx delay 0 steps: 2 + ceil(steps * 8 / 5) cycles
    apb(1'b1, 12'h104, 32'h0000A044);
    tx_pin_sel <= 3'h1;
    rx_pin_sel <= 3'h2;
    for (int k = 0; k < 2; k++) begin
      i_ptc_mac_model.pulse(k[0]);
      n = 0;
      while (sfd_pin_out[k] !== 1'b1 && n < 20) begin
        @(posedge ref_clk);
        #1;
        n++;
      end
      check(n, k ? 2 : 10, "indication delay");
    end
    $display("indication delay done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 12'h108, 32'(ph_wr[i]));
      @(posedge ref_clk);
      #1;
      check(32'(tx_clk_shift_stb), 32'(ph_wr[i][4]), "shift strobe");
      check(32'(tx_clk_phase), 32'(ph_exp[i]), "applied phase");
      check({25'h0, tx_clk_shift_ns}, 32'(sh_exp[i]), "shift amount");
    end
    rdchk(12'h108, 32'h00000007);
    apb(1'b1, 12'h108, 32'h0000FFE0);
    rdchk(12'h108, 32'h00000000);
    $display("phase shift done");
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, 12'h2B8, 32'(c << 6));
      rdchk(12'h2B8, 32'h00008020 | (c << 6));
      check(32'(power_back_off_level), c < 4 ? c : 0, "back-off level");
    end
    $display("back-off done");
    // host reads first, then writes with reserved bits zero
    rdchk(12'h340, 32'h00000000);
    apb(1'b1, 12'h340, 32'h00008005);
    repeat (2) @(posedge ref_clk);
    #1;
    check(32'({regulator_power_down, regulator_output_pin_en, regulator_ctrl}), 32'h25, "regulator");
    rdchk(12'h340, 32'h00000005);
    $display("regulator done");
    apb(1'b0, 12'h0FC, 32'h0);
    check({er, rd[30:0]}, 32'h80000000, "unmapped read");
    apb(1'b1, 12'h109, 32'h0000001F);
    check(32'(er), 32'h1, "unaligned write");
    rdchk(12'h108, 32'h00000000);
    $display("refusals done");
    end_of_test();
  end
endmodule
`default_nettype wire
